// ### design/toc_timer_compare.sv
// Output compare, forced compare, one-pulse, PWM, capture edge and
// timer clock selection of a 16-bit timer, behind a Wishbone slave.
// Assumes mclk is the CPU clock; pins arrive asynchronously.
//
// What this block does
// (R01) Flag clears after status read, then low access
// (R02) High byte write inhibits compare until low write
// (R03) Software writes high, reads status, writes low
// (R04) Disabled pin gets no level except pin one in one-pulse, PWM; flag still
// (R05) Flag and pin update on counter match
// (R06) Forced bit copies level, no flag
// (R07) Forced bits ignored in one-pulse, PWM
// (R08) Control one bit 3 forces pin one
// (R09) Control one bit 2 is level two
// (R10) Control one bit 1 capture one edge
// (R11) Control one bit 0 is level one
// (R12) Control two bit 7 enables pin one
// (R13) Control two bit 6 enables pin two
// (R14) Bit 5 one-pulse triggered by capture one
// (R15) Bit 4 PWM: width cmp one, period two
// (R16) Bits 3:2 select timer clock source
// (R17) External setting stops counter if pin absent
// (R18) Control two bit 1 capture two edge
// (R19) Control two bit 0 external clock edge
// (R20) 16-bit compare against counter per tick
`timescale 1ns/1ps
module toc_timer_compare
   import toc_pkg::*;
#(
   parameter bit EXT_CLK_PRESENT = 1'b1
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic capture_pin_one,
   input wire logic capture_pin_two,
   input wire logic external_timer_clock_pin,
   output logic compare_output_pin_one,
   output logic compare_output_pin_two,
   output logic compare_pin_one_timer_owned,
   output logic compare_pin_two_timer_owned,
   output logic capture_one_event,
   output logic capture_two_event,
   output logic compare_irq_request,
   output logic [15:0] timer_count
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic addr_is(input logic [7:0] adr,
                                    input logic [7:0] target);
      addr_is = ({adr[7:2], 2'b00} == target);
   endfunction : addr_is

   function automatic logic [15:0] set_high(input logic [15:0] v,
                                            input logic [7:0] b);
      set_high = {b, v[7:0]};
   endfunction : set_high

   function automatic logic [15:0] set_low(input logic [15:0] v,
                                           input logic [7:0] b);
      set_low = {v[15:8], b};
   endfunction : set_low

   // Prescaler has reached the last state of its division
   function automatic logic tick_due(input logic [2:0] pre,
                                     input logic [2:0] last);
      tick_due = ((pre & last) == last);
   endfunction : tick_due

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic cap1_rise;
   logic cap1_fall;
   logic cap2_rise;
   logic cap2_fall;
   logic ext_rise;
   logic ext_fall;

   toc_pin_sync u_sync_cap1 (
      .mclk(mclk),
      .rst(rst),
      .pin(capture_pin_one),
      .level(),
      .rise(cap1_rise),
      .fall(cap1_fall)
   );

   toc_pin_sync u_sync_cap2 (
      .mclk(mclk),
      .rst(rst),
      .pin(capture_pin_two),
      .level(),
      .rise(cap2_rise),
      .fall(cap2_fall)
   );

   toc_pin_sync u_sync_ext (
      .mclk(mclk),
      .rst(rst),
      .pin(external_timer_clock_pin),
      .level(),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   toc_state_t q_reg;
   toc_state_t q_next;

   logic req;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wbyte;
   logic ext_edge;
   logic ext_tick;
   logic tick;
   logic cap1_trig;
   logic cap2_trig;
   logic mode_pwm;
   logic mode_opm;
   logic pin1_en;
   logic pin2_en;
   logic [1:0] match;
   logic [1:0] clk_sel;

   assign req = wb_cyc_i & wb_stb_i;
   // Access completes at the edge where the master sees ack
   assign acc = req & q_reg.ack;
   assign wr = acc & wb_we_i & wb_sel_i[0];
   assign rd = acc & ~wb_we_i;
   assign wbyte = wb_dat_i[7:0];

   assign mode_pwm = q_reg.ctrl_two[TOC_C2_PWM];
   assign mode_opm = q_reg.ctrl_two[TOC_C2_ONE_PULSE];
   assign pin1_en = q_reg.ctrl_two[TOC_C2_PIN_ONE_EN];
   assign pin2_en = q_reg.ctrl_two[TOC_C2_PIN_TWO_EN];
   assign clk_sel = {q_reg.ctrl_two[TOC_C2_CLK_HI],
                     q_reg.ctrl_two[TOC_C2_CLK_LO]};

   // ----------------------------------------
   // Timer clock and capture edges
   // ----------------------------------------
   assign ext_edge = q_reg.ctrl_two[TOC_C2_EXT_EDGE] ? ext_rise
                                                     : ext_fall; // R19
   assign cap1_trig = q_reg.ctrl_one[TOC_C1_EDGE_ONE] ? cap1_rise
                                                      : cap1_fall; // R10
   assign cap2_trig = q_reg.ctrl_two[TOC_C2_EDGE_TWO] ? cap2_rise
                                                      : cap2_fall; // R18
   // Without the pin the external setting holds the counter
   assign ext_tick = EXT_CLK_PRESENT & ext_edge; // R17

   always_comb begin
      case (clk_sel) // R16
         TOC_CLK_DIV4: tick = tick_due(q_reg.pre, TOC_DIV4_LAST);
         TOC_CLK_DIV2: tick = tick_due(q_reg.pre, TOC_DIV2_LAST);
         TOC_CLK_DIV8: tick = tick_due(q_reg.pre, TOC_DIV8_LAST);
         TOC_CLK_EXT: begin
            tick = ext_tick; // R17
         end
         default: tick = 1'b0;
      endcase
   end

   // Compare once per new counter value, unless inhibited
   assign match[0] = q_reg.new_cnt & ~q_reg.inhibit[0]
                     & (q_reg.cnt == q_reg.cmp_one); // R20 R02
   assign match[1] = q_reg.new_cnt & ~q_reg.inhibit[1]
                     & (q_reg.cnt == q_reg.cmp_two); // R20 R02

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      q_next = q_reg;
      q_next.pre = q_reg.pre + 3'd1;
      q_next.ack = req & ~q_reg.ack;
      q_next.new_cnt = tick;
      if (tick) begin
         q_next.cnt = q_reg.cnt + 16'h0001;
      end

      // Read data captured when the request is first seen
      if (req & ~q_reg.ack & ~wb_we_i) begin
         if (addr_is(wb_adr_i, TOC_ADR_CTRL_ONE)) begin
            q_next.dat = q_reg.ctrl_one;
         end else if (addr_is(wb_adr_i, TOC_ADR_CTRL_TWO)) begin
            q_next.dat = q_reg.ctrl_two;
         end else if (addr_is(wb_adr_i, TOC_ADR_STATUS)) begin
            q_next.dat = {6'b000000, q_reg.flag};
         end else if (addr_is(wb_adr_i, TOC_ADR_CMP1_HI)) begin
            q_next.dat = q_reg.cmp_one[15:8];
         end else if (addr_is(wb_adr_i, TOC_ADR_CMP1_LO)) begin
            q_next.dat = q_reg.cmp_one[7:0];
         end else if (addr_is(wb_adr_i, TOC_ADR_CMP2_HI)) begin
            q_next.dat = q_reg.cmp_two[15:8];
         end else if (addr_is(wb_adr_i, TOC_ADR_CMP2_LO)) begin
            q_next.dat = q_reg.cmp_two[7:0];
         end else if (addr_is(wb_adr_i, TOC_ADR_CNT_HI)) begin
            q_next.dat = q_reg.cnt[15:8];
         end else if (addr_is(wb_adr_i, TOC_ADR_CNT_LO)) begin
            q_next.dat = q_reg.cnt[7:0];
         end else begin
            q_next.dat = 8'h00;
         end
      end

      // ----------------------------------------
      // Register writes and access side effects
      // ----------------------------------------
      if (wr && addr_is(wb_adr_i, TOC_ADR_CTRL_ONE)) begin
         q_next.ctrl_one = wbyte & TOC_C1_WRITE_MASK;
         // Forced compare acts only outside one-pulse and PWM
         if (!mode_pwm && !mode_opm) begin // R07
            if (wbyte[TOC_C1_FORCE_ONE] && pin1_en) begin
               q_next.pin_one = wbyte[TOC_C1_LEVEL_ONE]; // R06 R08
            end
            if (wbyte[TOC_C1_FORCE_TWO] && pin2_en) begin
               q_next.pin_two = wbyte[TOC_C1_LEVEL_TWO]; // R06
            end
         end
      end
      if (wr && addr_is(wb_adr_i, TOC_ADR_CTRL_TWO)) begin
         q_next.ctrl_two = wbyte;
      end
      if (wr && addr_is(wb_adr_i, TOC_ADR_CMP1_HI)) begin
         q_next.cmp_one = set_high(q_reg.cmp_one, wbyte);
         q_next.inhibit[0] = 1'b1; // R02
      end
      if (wr && addr_is(wb_adr_i, TOC_ADR_CMP2_HI)) begin
         q_next.cmp_two = set_high(q_reg.cmp_two, wbyte);
         q_next.inhibit[1] = 1'b1; // R02
      end
      if (wr && addr_is(wb_adr_i, TOC_ADR_CMP1_LO)) begin
         q_next.cmp_one = set_low(q_reg.cmp_one, wbyte);
         q_next.inhibit[0] = 1'b0; // R02
      end
      if (wr && addr_is(wb_adr_i, TOC_ADR_CMP2_LO)) begin
         q_next.cmp_two = set_low(q_reg.cmp_two, wbyte);
         q_next.inhibit[1] = 1'b0; // R02
      end

      // Status read arms the clear of flags that were set
      if (rd && addr_is(wb_adr_i, TOC_ADR_STATUS)) begin
         q_next.armed[0] = q_reg.dat[TOC_SR_FLAG_ONE]; // R01
         q_next.armed[1] = q_reg.dat[TOC_SR_FLAG_TWO]; // R01
      end
      // Any access to a low byte completes the clear
      if (acc && addr_is(wb_adr_i, TOC_ADR_CMP1_LO)) begin
         if (q_reg.armed[0]) begin
            q_next.flag[0] = 1'b0; // R01
         end
         q_next.armed[0] = 1'b0;
      end
      if (acc && addr_is(wb_adr_i, TOC_ADR_CMP2_LO)) begin
         if (q_reg.armed[1]) begin
            q_next.flag[1] = 1'b0; // R01
         end
         q_next.armed[1] = 1'b0;
      end

      // Match sets the flag in every mode; set wins over clear
      if (match[0]) begin
         q_next.flag[0] = 1'b1; // R05 R04
      end
      if (match[1]) begin
         q_next.flag[1] = 1'b1; // R05 R04
      end

      // ----------------------------------------
      // Waveform generation
      // ----------------------------------------
      if (mode_pwm) begin
         if (match[0]) begin
            q_next.pin_one = q_reg.ctrl_one[TOC_C1_LEVEL_ONE]; // R15
         end
         if (match[1]) begin
            q_next.pin_one = q_reg.ctrl_one[TOC_C1_LEVEL_TWO]; // R15 R09
            q_next.cnt = TOC_CNT_RELOAD; // R15
         end
      end else if (mode_opm) begin
         if (cap1_trig) begin
            q_next.pin_one = q_reg.ctrl_one[TOC_C1_LEVEL_TWO]; // R14 R09
            q_next.cnt = TOC_CNT_RELOAD; // R14
         end else if (match[0]) begin
            q_next.pin_one = q_reg.ctrl_one[TOC_C1_LEVEL_ONE]; // R14
         end
      end else if (match[0] && pin1_en) begin
         q_next.pin_one = q_reg.ctrl_one[TOC_C1_LEVEL_ONE]; // R11 R04
      end
      if (!mode_pwm && !mode_opm && match[1] && pin2_en) begin
         q_next.pin_two = q_reg.ctrl_one[TOC_C1_LEVEL_TWO]; // R09 R04
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q_reg.ctrl_one <= TOC_CTRL_ONE_RST;
         q_reg.ctrl_two <= TOC_CTRL_TWO_RST;
         q_reg.cmp_one <= TOC_CMP_RST;
         q_reg.cmp_two <= TOC_CMP_RST;
         q_reg.inhibit <= 2'b00;
         q_reg.flag <= 2'b00;
         q_reg.armed <= 2'b00;
         q_reg.cnt <= TOC_CNT_RST;
         q_reg.pre <= TOC_PRE_RST;
         q_reg.new_cnt <= 1'b0;
         q_reg.pin_one <= 1'b0;
         q_reg.pin_two <= 1'b0;
         q_reg.ack <= 1'b0;
         q_reg.dat <= 8'h00;
      end else begin
         q_reg <= q_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign wb_ack_o = q_reg.ack;
   assign wb_dat_o = {24'h00_0000, q_reg.dat};
   assign compare_output_pin_one = q_reg.pin_one;
   assign compare_output_pin_two = q_reg.pin_two;
   assign compare_pin_one_timer_owned = pin1_en; // R12
   assign compare_pin_two_timer_owned = pin2_en; // R13
   assign capture_one_event = cap1_trig;
   assign capture_two_event = cap2_trig;
   assign compare_irq_request = q_reg.ctrl_one[TOC_C1_IRQ_EN]
                                & (|q_reg.flag); // R04
   assign timer_count = q_reg.cnt;

endmodule : toc_timer_compare

// ### design/toc_pkg.sv
// Constants and state types of the timer output compare control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package toc_pkg;

   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] TOC_ADR_CTRL_ONE = 8'h00;
   localparam logic [7:0] TOC_ADR_CTRL_TWO = 8'h04;
   localparam logic [7:0] TOC_ADR_STATUS = 8'h08;
   localparam logic [7:0] TOC_ADR_CMP1_HI = 8'h0C;
   localparam logic [7:0] TOC_ADR_CMP1_LO = 8'h10;
   localparam logic [7:0] TOC_ADR_CMP2_HI = 8'h14;
   localparam logic [7:0] TOC_ADR_CMP2_LO = 8'h18;
   localparam logic [7:0] TOC_ADR_CNT_HI = 8'h1C;
   localparam logic [7:0] TOC_ADR_CNT_LO = 8'h20;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int TOC_C1_LEVEL_ONE = 0;
   localparam int TOC_C1_EDGE_ONE = 1;
   localparam int TOC_C1_LEVEL_TWO = 2;
   localparam int TOC_C1_FORCE_ONE = 3;
   localparam int TOC_C1_FORCE_TWO = 4;
   localparam int TOC_C1_IRQ_EN = 6;
   localparam int TOC_C2_EXT_EDGE = 0;
   localparam int TOC_C2_EDGE_TWO = 1;
   localparam int TOC_C2_CLK_LO = 2;
   localparam int TOC_C2_CLK_HI = 3;
   localparam int TOC_C2_PWM = 4;
   localparam int TOC_C2_ONE_PULSE = 5;
   localparam int TOC_C2_PIN_TWO_EN = 6;
   localparam int TOC_C2_PIN_ONE_EN = 7;
   localparam int TOC_SR_FLAG_ONE = 0;
   localparam int TOC_SR_FLAG_TWO = 1;
   localparam logic [7:0] TOC_C1_WRITE_MASK = 8'h5F;

   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [7:0] TOC_CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] TOC_CTRL_TWO_RST = 8'h00;
   localparam logic [15:0] TOC_CMP_RST = 16'hFFFF;
   localparam logic [15:0] TOC_CNT_RST = 16'h0000;
   localparam logic [15:0] TOC_CNT_RELOAD = 16'h0000;
   localparam logic [2:0] TOC_PRE_RST = 3'h0;

   // Prescaler states that end one timer tick
   localparam logic [2:0] TOC_DIV2_LAST = 3'h1;
   localparam logic [2:0] TOC_DIV4_LAST = 3'h3;
   localparam logic [2:0] TOC_DIV8_LAST = 3'h7;

   // Timer clock selection codes
   localparam logic [1:0] TOC_CLK_DIV4 = 2'b00;
   localparam logic [1:0] TOC_CLK_DIV2 = 2'b01;
   localparam logic [1:0] TOC_CLK_DIV8 = 2'b10;
   localparam logic [1:0] TOC_CLK_EXT = 2'b11;

   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
      logic fall;
   } toc_sync_t;

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [15:0] cmp_one;
      logic [15:0] cmp_two;
      logic [1:0] inhibit;
      logic [1:0] flag;
      logic [1:0] armed;
      logic [15:0] cnt;
      logic [2:0] pre;
      logic new_cnt;
      logic pin_one;
      logic pin_two;
      logic ack;
      logic [7:0] dat;
   } toc_state_t;

endpackage : toc_pkg

// ### design/toc_pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin; one clock domain.
`timescale 1ns/1ps
module toc_pin_sync
   import toc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);

   toc_sync_t q_reg;
   toc_sync_t q_next;

   always_comb begin
      q_next = q_reg;
      q_next.s1 = pin;
      q_next.s2 = q_reg.s1;
      q_next.s3 = q_reg.s2;
      q_next.rise = 1'b0;
      q_next.fall = 1'b0;
      // Accept a change once second and third stages agree
      if ((q_reg.s2 == q_reg.s3) && (q_reg.s3 != q_reg.level)) begin
         q_next.level = q_reg.s3;
         q_next.rise = q_reg.s3;
         q_next.fall = ~q_reg.s3;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign level = q_reg.level;
   assign rise = q_reg.rise;
   assign fall = q_reg.fall;

endmodule : toc_pin_sync

// ### tb/toc_timer_compare_chk.sv
// Checker for the timer output compare block, bound to its top module.
// Sees only that module's ports; shadows both control registers.
`timescale 1ns/1ps
module toc_timer_compare_chk
   import toc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic compare_output_pin_one,
   input wire logic compare_output_pin_two,
   input wire logic compare_pin_one_timer_owned,
   input wire logic compare_pin_two_timer_owned,
   input wire logic capture_one_event,
   input wire logic compare_irq_request,
   input wire logic [15:0] timer_count
);
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   logic wr;
   logic wr1;
   logic wr2;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign wr1 = wr && wb_adr_i[7:2] == TOC_ADR_CTRL_ONE[7:2];
   assign wr2 = wr && wb_adr_i[7:2] == TOC_ADR_CTRL_TWO[7:2];
   // --------------------------------
   // Control register shadows
   // --------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         c1_reg <= TOC_CTRL_ONE_RST;
         c2_reg <= TOC_CTRL_TWO_RST;
      end else begin
         if (wr1) begin
            c1_reg <= wb_dat_i[7:0];
         end
         if (wr2) begin
            c2_reg <= wb_dat_i[7:0];
         end
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // --------------------------------
   // Assertions
   // --------------------------------
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack high two cycles");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   pin_one_own_a: assert property (wr2 |=>
      compare_pin_one_timer_owned == $past(wb_dat_i[7]))
      else $error("pin one ownership wrong");
   pin_two_own_a: assert property (wr2 |=>
      compare_pin_two_timer_owned == $past(wb_dat_i[6]))
      else $error("pin two ownership wrong");
   force_one_a: assert property (wr1 && wb_dat_i[3] && c2_reg[7] &&
      c2_reg[5:4] == 2'h0 |=> compare_output_pin_one == $past(wb_dat_i[0]))
      else $error("forced level one not on pin");
   force_two_a: assert property (wr1 && wb_dat_i[4] && c2_reg[6] &&
      c2_reg[5:4] == 2'h0 |=> compare_output_pin_two == $past(wb_dat_i[2]))
      else $error("forced level two not on pin");
   irq_gate_a: assert property (!c1_reg[6] |-> !compare_irq_request)
      else $error("interrupt while disabled");
   div4_rate_a: assert property ($changed(timer_count) &&
      $past(c2_reg[5:2]) == 4'h0 |=>
      ($stable(timer_count) || $past(c2_reg[5:2]) != 4'h0) [*3])
      else $error("counter faster than one tick in four");
   cap_pulse_a: assert property (capture_one_event |=>
      !capture_one_event) else $error("capture event too long");
endmodule : toc_timer_compare_chk

bind toc_timer_compare toc_timer_compare_chk chk (.mclk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
   .compare_output_pin_one, .compare_output_pin_two,
   .compare_pin_one_timer_owned, .compare_pin_two_timer_owned,
   .capture_one_event, .compare_irq_request, .timer_count);

// ### tb/toc_pins_model.sv
// Model of the circuitry on the capture and external clock pins.
// Capture levels follow the bench; clock pin runs only while asked.
`timescale 1ns/1ps
module toc_pins_model #(
   parameter int HALF = 4
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ext_run,
   input wire logic cap_one_level,
   input wire logic cap_two_level,
   output logic capture_pin_one,
   output logic capture_pin_two,
   output logic external_timer_clock_pin
);
   int cnt_reg;
   assign capture_pin_one = cap_one_level;
   assign capture_pin_two = cap_two_level;
   // Clock pin stands still when not running
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 0;
         external_timer_clock_pin <= 1'b0;
      end else if (ext_run) begin
         if (cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            external_timer_clock_pin <= !external_timer_clock_pin;
         end else begin
            cnt_reg <= cnt_reg + 1;
         end
      end
   end
endmodule : toc_pins_model

// ### tb/tb_timer_output_compare_control.sv
// Self-checking bench for the timer output compare block.
// Drives the Wishbone side and the pin model; one task per scenario.
`timescale 1ns/1ps
module tb_timer_output_compare_control;
   import toc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, capture_pin_one, capture_pin_two, external_timer_clock_pin;
   logic compare_output_pin_one, compare_output_pin_two;
   logic compare_pin_one_timer_owned, compare_pin_two_timer_owned;
   logic capture_one_event, capture_two_event, compare_irq_request;
   logic [15:0] timer_count;
   logic ext_run = 1'b0, cap_one_level = 1'b0, cap_two_level = 1'b0;
   int miscompares = 0, samples_checked = 0, cycles = 0, ev1 = 0, ev2 = 0;

   toc_timer_compare dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_pin_one,
      .capture_pin_two, .external_timer_clock_pin, .compare_output_pin_one,
      .compare_output_pin_two, .compare_pin_one_timer_owned,
      .compare_pin_two_timer_owned, .capture_one_event, .capture_two_event,
      .compare_irq_request, .timer_count);
   toc_pins_model pins (.mclk, .rst, .ext_run, .cap_one_level,
      .cap_two_level, .capture_pin_one, .capture_pin_two,
      .external_timer_clock_pin);

   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (capture_one_event === 1'b1) ev1++;
      if (capture_two_event === 1'b1) ev2++;
      if (cycles == 6000) begin
         miscompares++;
         conclude();
      end
   end
   // --------------------------------
   // Shared tasks
   // --------------------------------
   task automatic chk(input string s, input logic [15:0] e,
      input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= 32'(d);
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o[7:0];
      chk("ack", 1'b1, wb_ack_o);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk($sformatf("read %h", a), e, q);
   endtask : rd
   task automatic fw(input logic [7:0] d, input logic e1, input logic e2);
      wr(TOC_ADR_CTRL_ONE, d);
      @(posedge mclk);
      chk("pin one", e1, compare_output_pin_one);
      chk("pin two", e2, compare_output_pin_two);
   endtask : fw
   // --------------------------------
   // Scenarios
   // --------------------------------
   task automatic t_reset;
      rd(TOC_ADR_CTRL_ONE, TOC_CTRL_ONE_RST);
      rd(TOC_ADR_CTRL_TWO, TOC_CTRL_TWO_RST);
      rd(TOC_ADR_STATUS, 8'h00);
      rd(8'hFC, 8'h00);
   endtask : t_reset
   task automatic t_compare;
      logic [7:0] c, q;
      int n;
      wr(TOC_ADR_CTRL_TWO, 8'h80);
      wr(TOC_ADR_CTRL_ONE, 8'h45);
      c = timer_count[7:0] + 8'h18;
      wr(TOC_ADR_CMP1_HI, 8'h00);
      rd(TOC_ADR_STATUS, 8'h00);
      wr(TOC_ADR_CMP1_LO, c);
      wr(TOC_ADR_CMP2_HI, 8'h00);
      wr(TOC_ADR_CMP2_LO, c);
      for (n = 0; n < 300 && compare_output_pin_one !== 1'b1; n++)
         @(posedge mclk);
      chk("count at match", {8'h00, c}, timer_count);
      chk("pin one", 1'b1, compare_output_pin_one);
      repeat (2) @(posedge mclk);
      chk("pin two", 1'b0, compare_output_pin_two);
      chk("irq", 1'b1, compare_irq_request);
      bus(TOC_ADR_CMP1_LO, 1'b0, 8'h00, q);
      rd(TOC_ADR_STATUS, 8'h03);
      bus(TOC_ADR_CMP1_LO, 1'b0, 8'h00, q);
      rd(TOC_ADR_STATUS, 8'h02);
      c = timer_count[7:0] + 8'h10;
      wr(TOC_ADR_CMP1_LO, c);
      wr(TOC_ADR_CMP1_HI, 8'h00);
      repeat (100) @(posedge mclk);
      rd(TOC_ADR_STATUS, 8'h02);
   endtask : t_compare
   task automatic t_force;
      wr(TOC_ADR_CTRL_TWO, 8'hC0);
      fw(8'h08, 1'b0, 1'b0);
      fw(8'h09, 1'b1, 1'b0);
      fw(8'h14, 1'b1, 1'b1);
      fw(8'h10, 1'b1, 1'b0);
      rd(TOC_ADR_STATUS, 8'h02);
      wr(TOC_ADR_CTRL_TWO, 8'hA0);
      fw(8'h1C, 1'b1, 1'b0);
   endtask : t_force
   task automatic t_capture;
      for (int s = 0; s < 2; s++) begin
         wr(TOC_ADR_CTRL_TWO, s ? 8'h02 : 8'h00);
         wr(TOC_ADR_CTRL_ONE, s ? 8'h02 : 8'h00);
         ev1 = 0;
         ev2 = 0;
         cap_one_level <= 1'b1;
         cap_two_level <= 1'b1;
         repeat (12) @(posedge mclk);
         chk("rise one", 16'(s), 16'(ev1));
         chk("rise two", 16'(s), 16'(ev2));
         cap_one_level <= 1'b0;
         cap_two_level <= 1'b0;
         repeat (12) @(posedge mclk);
         chk("fall one", 16'h0001, 16'(ev1));
         chk("fall two", 16'h0001, 16'(ev2));
      end
   endtask : t_capture
   task automatic t_pulse;
      int n;
      wr(TOC_ADR_CMP1_HI, 8'h00);
      wr(TOC_ADR_CMP1_LO, 8'h10);
      wr(TOC_ADR_CTRL_TWO, 8'h80);
      wr(TOC_ADR_CTRL_ONE, 8'h0E);
      wr(TOC_ADR_CTRL_TWO, 8'hA0);
      cap_one_level <= 1'b1;
      for (n = 0; n < 40 && compare_output_pin_one !== 1'b1; n++)
         @(posedge mclk);
      chk("pulse start", 1'b1, compare_output_pin_one);
      for (n = 0; n < 200 && compare_output_pin_one !== 1'b0; n++)
         @(posedge mclk);
      chk("pulse end count", 16'h0010, timer_count);
      wr(TOC_ADR_CTRL_ONE, 8'h01);
      wr(TOC_ADR_CMP1_LO, 8'h08);
      wr(TOC_ADR_CMP2_HI, 8'h00);
      wr(TOC_ADR_CMP2_LO, 8'h28);
      wr(TOC_ADR_CTRL_TWO, 8'h90);
      for (n = 0; n < 600 && compare_output_pin_one !== 1'b1; n++)
         @(posedge mclk);
      for (n = 0; n < 400 && compare_output_pin_one !== 1'b0; n++)
         @(posedge mclk);
      chk("pwm high cycles", 16'h0080, 16'(n));
      repeat (8) @(posedge mclk);
      chk("pwm restart", 1'b1, timer_count < 16'h0004);
   endtask : t_pulse
   task automatic t_clock;
      logic [15:0] a;
      logic [7:0] cfg [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h0D, 8'h0D};
      logic [15:0] ex [6] = '{16'h0010, 16'h0020, 16'h0008, 16'h0008,
         16'h0008, 16'h0000};
      for (int i = 0; i < 6; i++) begin
         ext_run <= (i == 3 || i == 4);
         wr(TOC_ADR_CTRL_TWO, cfg[i]);
         repeat (16) @(posedge mclk);
         a = timer_count;
         repeat (64) @(posedge mclk);
         chk("ticks", ex[i], timer_count - a);
      end
   endtask : t_clock
   task automatic conclude;
      $display("miscompares %0d samples_checked %0d", miscompares,
         samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_compare();
      t_force();
      t_capture();
      t_pulse();
      t_clock();
      conclude();
   end
endmodule : tb_timer_output_compare_control
